// ---- rtl/rfc_consts.svh ----
// Constants for the RF frame and receive configuration block
//
// Contract
// - Low byte sets guard time bits 7..0
// - Guard time is eleven bits wide
// - Upper guard bits sit at control bits 5..3
// - Unit is 16 carrier cycles or half bit
// - Origin bit picks end of transmit or receive
// - Transmit parity appended per byte when enabled
// - Receive parity checked, never stored in FIFO
// - Stop symbol field selects none or symbol 1..3
// - Start symbol field selects none or symbol 1..3
// - Frame begin with enable raises interrupt
// - Frame begin seen flag sticky until cleared
// - Subcarrier with enable raises same interrupt
// - Subcarrier seen flag sticky until cleared
// - Subcarrier live bit follows detector directly
// - Partial byte store writes incomplete final byte; with continuous receive the error byte is written in its place
// - Continuous receive keeps receiver running after frame
// - Continuous receive appends error byte per frame
// - Early error discards bytes and resets FIFO
// - Collision counts as error under suppression
// - Short frame is disturbance, no receive interrupt
// - Rate code 2 is 26 kBd, 3 is 52 kBd
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses = 4 x index)
// ----------------------------------------------------------------
`define RFC_IDX_GUARD_CTRL 8'h31
`define RFC_IDX_GUARD_LOW 8'h32
`define RFC_IDX_FRAME_CTRL 8'h33
`define RFC_IDX_BEGIN_DET 8'h34
`define RFC_IDX_RECV_CTRL 8'h35
`define RFC_IDX_STATUS 8'h3a

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RFC_GC_ORIGIN 7
`define RFC_GC_UNIT 6
`define RFC_GC_HI_MSB 5
`define RFC_GC_HI_LSB 3
`define RFC_FC_TXPAR 7
`define RFC_FC_RXPAR 6
`define RFC_BD_SOF_EN 5
`define RFC_BD_SOF_SEEN 4
`define RFC_BD_SUBCARRIER_IRQ_ENABLE 2
`define RFC_BD_SUBC_SEEN 1
`define RFC_BD_SUBC_LIVE 0
`define RFC_RC_PARTIAL 7
`define RFC_RC_MULTI 6
`define RFC_RC_DISTURB 3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RFC_RST_GUARD_CTRL 8'hc0
`define RFC_RST_ZERO 8'h00
`define RFC_RATE_26K 3'h2
`define RFC_RATE_52K 3'h3
`define RFC_CLK_HZ 125000000
`define RFC_CARRIER_HZ 13560000
`define RFC_CARRIER_CYC 16
// 16 carrier cycles at 125 MHz, rounded down to 147 clock cycles
`define RFC_UNIT_CARRIER ((`RFC_CARRIER_CYC * `RFC_CLK_HZ) / `RFC_CARRIER_HZ)
`define RFC_BAUD_26K 26000
`define RFC_BAUD_52K 52000
// Half a bit period in clock cycles
`define RFC_HALF_26K (`RFC_CLK_HZ / (2 * `RFC_BAUD_26K))
`define RFC_HALF_52K (`RFC_CLK_HZ / (2 * `RFC_BAUD_52K))
`define RFC_EARLY_BYTES 2'd3

`endif

// ---- rtl/rfc_pkg.sv ----
// Types for the RF frame and receive configuration block
package rfc_pkg;

	// Avalon-MM request from the host
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} rfc_avm_req_t;

	// Avalon-MM answer to the host
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} rfc_avm_rsp_t;

	// Events from the receive datapath
	typedef struct packed {
		logic sof;        // Frame begin detected
		logic subc;       // Subcarrier level
		logic byte_vld;   // Full byte received
		logic [7:0] data; // Received byte
		logic par_bit;    // Received parity bit
		logic partial;    // Incomplete last byte present
		logic err;        // Reception error
		logic coll;       // Bit collision
		logic frame_end;  // End of received frame
		logic tx_end;     // End of transmitted data
		logic [7:0] err_reg; // Current error register contents
	} rfc_rx_ev_t;

	// Guard-timer state
	typedef enum logic [1:0] {
		RFC_G_IDLE = 2'b00,
		RFC_G_COUNT = 2'b01,
		RFC_G_DONE = 2'b11
	} rfc_gstate_t;

	// Write toward the receive FIFO
	typedef struct packed {
		logic wr;
		logic [7:0] data;
		logic flush;
	} rfc_fifo_wr_t;

endpackage : rfc_pkg

// ---- rtl/rfc_guard_timer.sv ----
// Transmit guard-time counter
`timescale 1ns/1ps
`default_nettype none
`include "rfc_consts.svh"
module rfc_guard_timer (
	input wire logic mclk,               // System clock
	input wire logic srst,               // Synchronous reset
	input wire logic [10:0] guard_time,  // Eleven-bit guard count
	input wire logic [15:0] unit_cyc,    // Clock cycles per count
	input wire logic start,              // Origin event pulse
	output logic open_q                  // Transmission allowed
);
	import rfc_pkg::*;

	typedef struct packed {
		rfc_gstate_t st;
		logic [10:0] cnt;
		logic [15:0] sub;
		logic open;
	} rfc_gt_state_t;

	rfc_gt_state_t s_q, s_d;

	// Count units of the selected length after each origin event
	always_comb begin
		s_d = s_q;
		case (s_q.st)
			RFC_G_IDLE: begin
				s_d.open = 1'b1;
			end
			RFC_G_COUNT: begin
				if (s_q.cnt == 11'h000) begin
					s_d.st = RFC_G_DONE;
				end else if (s_q.sub >= unit_cyc - 16'h0001) begin
					s_d.sub = 16'h0000;
					s_d.cnt = s_q.cnt - 11'h001;
				end else begin
					s_d.sub = s_q.sub + 16'h0001;
				end
			end
			RFC_G_DONE: begin
				s_d.open = 1'b1;
				s_d.st = RFC_G_IDLE;
			end
			default: begin
				s_d.st = RFC_G_IDLE;
			end
		endcase
		if (start) begin
			s_d.st = RFC_G_COUNT;
			s_d.cnt = guard_time;
			s_d.sub = 16'h0000;
			s_d.open = 1'b0;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_q <= '{st: RFC_G_IDLE, cnt: 11'h000, sub: 16'h0000, open: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign open_q = s_q.open;

	chk_guard_closed: assert property (@(posedge mclk) disable iff (srst)
		start && guard_time > 11'h001 |=> !open_q [*2])
		else $error("guard opened too early");

endmodule : rfc_guard_timer
`default_nettype wire

// ---- rtl/rfc_frame_cfg.sv ----
// RF frame and receive configuration registers with receive filter
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rfc_consts.svh"
module rfc_frame_cfg (
	input wire logic mclk,                        // System clock
	input wire logic srst,                        // Synchronous reset
	input wire rfc_pkg::rfc_avm_req_t avm_req,    // Avalon-MM request
	output rfc_pkg::rfc_avm_rsp_t avm_rsp,        // Avalon-MM answer
	input wire rfc_pkg::rfc_rx_ev_t rx_ev_in,     // Receiver events, other domain
	input wire logic tx_req,                      // Transmit request
	output logic tx_go_q,                         // Transmit start granted
	output logic send_parity_append_q,            // Parity append enable
	output logic [1:0] frame_end_symbol_sel_q,    // Stop symbol code
	output logic [1:0] frame_begin_symbol_sel_q,  // Start symbol code
	output logic [2:0] bitstream_frequency_q,     // Receive rate code
	output logic rate_valid_q,                    // Rate code is supported
	output logic receiver_active_q,               // Receiver running
	output rfc_pkg::rfc_fifo_wr_t fifo_wr_q,      // FIFO write port
	output logic rx_done_irq_q,                   // Receive complete pulse
	output logic frame_begin_irq_q                // Frame begin interrupt level
);
	import rfc_pkg::*;

	// All state of this block
	typedef struct packed {
		rfc_rx_ev_t ev1;
		rfc_rx_ev_t ev2;
		logic [7:0] guard_ctrl;
		logic [7:0] guard_low;
		logic [7:0] frame_ctrl;
		logic [7:0] begin_det;
		logic [7:0] recv_ctrl;
		logic [31:0] rdata;
		logic ack;
		logic in_frame;
		logic [1:0] byte_cnt;
		logic early_err;
		logic active;
		logic [7:0] fifo_data;
		logic fifo_wr;
		logic fifo_flush;
		logic rx_done;
		logic irq;
		logic txgo;
		logic tx_pend;
		logic last_rx;
		logic last_tx;
		logic rate_ok;
	} rfc_state_t;

	rfc_state_t s_q, s_d;
	rfc_rx_ev_t ev;
	logic guard_open;
	logic [10:0] guard_time;
	logic [15:0] unit_cyc;
	logic guard_start;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Register index from a word byte address
	function automatic logic [5:0] rfc_idx(input logic [7:0] addr);
		rfc_idx = addr[7:2];
	endfunction : rfc_idx

	// Odd parity over a byte plus its parity bit
	function automatic logic rfc_par_ok(input logic [7:0] d, input logic p);
		rfc_par_ok = ^{d, p};
	endfunction : rfc_par_ok

	// Index compare against a full constant
	function automatic logic rfc_hit(input logic [7:0] addr, input logic [7:0] idx);
		rfc_hit = ({2'b00, rfc_idx(addr)} == idx);
	endfunction : rfc_hit

	// ----------------------------------------------------------------
	// Guard time assembly and timer
	// ----------------------------------------------------------------

	// Eleven-bit value: control bits 5..3 over the low byte
	assign guard_time = {s_q.guard_ctrl[`RFC_GC_HI_MSB:`RFC_GC_HI_LSB],
		s_q.guard_low};

	// Length of one count: carrier unit or half a bit period
	always_comb begin
		if (!s_q.guard_ctrl[`RFC_GC_UNIT]) begin
			unit_cyc = 16'(`RFC_UNIT_CARRIER);
		end else if (s_q.recv_ctrl[2:0] == `RFC_RATE_52K) begin
			unit_cyc = 16'(`RFC_HALF_52K);
		end else begin
			unit_cyc = 16'(`RFC_HALF_26K);
		end
	end

	// Origin selects end of transmit or end of receive
	assign guard_start = s_q.guard_ctrl[`RFC_GC_ORIGIN] ? (ev.frame_end && !s_q.last_rx)
		: (ev.tx_end && !s_q.last_tx);

	rfc_guard_timer u_guard (
		.mclk(mclk),
		.srst(srst),
		.guard_time(guard_time),
		.unit_cyc(unit_cyc),
		.start(guard_start),
		.open_q(guard_open)
	);

	// Two-stage synchronised receiver events
	assign ev = s_q.ev2;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic err_now;
		logic par_bad;
		err_now = 1'b0;
		par_bad = 1'b0;
		s_d = s_q;
		s_d.ev1 = rx_ev_in;
		s_d.ev2 = s_q.ev1;
		s_d.last_rx = ev.frame_end;
		s_d.last_tx = ev.tx_end;
		s_d.ack = 1'b0;
		s_d.fifo_wr = 1'b0;
		s_d.fifo_flush = 1'b0;
		s_d.rx_done = 1'b0;
		s_d.txgo = 1'b0;

		// Bus: one wait cycle, then answer
		if ((avm_req.read || avm_req.write) && !s_q.ack) begin
			s_d.ack = 1'b1;
			s_d.rdata = 32'h0000_0000;
			if (avm_req.read) begin
				if (rfc_hit(avm_req.address, `RFC_IDX_GUARD_CTRL)) begin
					s_d.rdata[7:0] = s_q.guard_ctrl & 8'hf8;
				end else if (rfc_hit(avm_req.address, `RFC_IDX_GUARD_LOW)) begin
					s_d.rdata[7:0] = s_q.guard_low;
				end else if (rfc_hit(avm_req.address, `RFC_IDX_FRAME_CTRL)) begin
					s_d.rdata[7:0] = s_q.frame_ctrl & 8'hcf;
				end else if (rfc_hit(avm_req.address, `RFC_IDX_BEGIN_DET)) begin
					s_d.rdata[7:0] = {s_q.begin_det[7:1] & 7'h1b, ev.subc};
				end else if (rfc_hit(avm_req.address, `RFC_IDX_RECV_CTRL)) begin
					s_d.rdata[7:0] = s_q.recv_ctrl & 8'hcf;
				end else if (rfc_hit(avm_req.address, `RFC_IDX_STATUS)) begin
					s_d.rdata[7:0] = {5'h00, s_q.active, guard_open, s_q.in_frame};
				end
			end
		end

		// A write lands only at the edge where waitrequest is seen low
		if (avm_req.write && s_q.ack) begin
			if (rfc_hit(avm_req.address, `RFC_IDX_GUARD_CTRL)) begin
				s_d.guard_ctrl = avm_req.writedata[7:0] & 8'hf8;
			end else if (rfc_hit(avm_req.address, `RFC_IDX_GUARD_LOW)) begin
				s_d.guard_low = avm_req.writedata[7:0];
			end else if (rfc_hit(avm_req.address, `RFC_IDX_FRAME_CTRL)) begin
				s_d.frame_ctrl = avm_req.writedata[7:0] & 8'hcf;
			end else if (rfc_hit(avm_req.address, `RFC_IDX_BEGIN_DET)) begin
				// Enables written; writing 0 to a seen flag clears it
				s_d.begin_det[`RFC_BD_SOF_EN] = avm_req.writedata[`RFC_BD_SOF_EN];
				s_d.begin_det[`RFC_BD_SUBCARRIER_IRQ_ENABLE] = avm_req.writedata[`RFC_BD_SUBCARRIER_IRQ_ENABLE];
				s_d.begin_det[`RFC_BD_SOF_SEEN] = s_q.begin_det[`RFC_BD_SOF_SEEN]
					& avm_req.writedata[`RFC_BD_SOF_SEEN];
				s_d.begin_det[`RFC_BD_SUBC_SEEN] = s_q.begin_det[`RFC_BD_SUBC_SEEN]
					& avm_req.writedata[`RFC_BD_SUBC_SEEN];
			end else if (rfc_hit(avm_req.address, `RFC_IDX_RECV_CTRL)) begin
				s_d.recv_ctrl = avm_req.writedata[7:0] & 8'hcf;
				s_d.active = 1'b1;
			end
		end
		// Rate decode kept in a flop so the output needs no logic
		s_d.rate_ok = (s_d.recv_ctrl[2:1] == 2'b01); // Codes 2 and 3 only

		// Sticky seen flags: set wins over the clear above
		if (ev.sof) begin
			s_d.begin_det[`RFC_BD_SOF_SEEN] = 1'b1;
		end
		if (ev.subc) begin
			s_d.begin_det[`RFC_BD_SUBC_SEEN] = 1'b1;
		end
		s_d.begin_det[0] = 1'b0;
		s_d.irq = (s_d.begin_det[`RFC_BD_SOF_EN] && s_d.begin_det[`RFC_BD_SOF_SEEN])
			|| (s_d.begin_det[`RFC_BD_SUBCARRIER_IRQ_ENABLE] && s_d.begin_det[`RFC_BD_SUBC_SEEN]);

		// Receive path
		par_bad = s_q.frame_ctrl[`RFC_FC_RXPAR] && ev.byte_vld
			&& !rfc_par_ok(ev.data, ev.par_bit);
		err_now = ev.err || par_bad
			|| (s_q.recv_ctrl[`RFC_RC_DISTURB] && ev.coll);
		if (ev.sof && s_q.active) begin
			s_d.in_frame = 1'b1;
			s_d.byte_cnt = 2'd0;
			s_d.early_err = 1'b0;
		end
		if (s_q.in_frame) begin
			if (ev.byte_vld) begin
				s_d.fifo_wr = 1'b1; // Parity bit is never stored
				s_d.fifo_data = ev.data;
				if (s_q.byte_cnt != `RFC_EARLY_BYTES) begin
					s_d.byte_cnt = s_q.byte_cnt + 2'd1;
				end
			end
			if (err_now && s_q.recv_ctrl[`RFC_RC_DISTURB]
				&& s_q.byte_cnt != `RFC_EARLY_BYTES) begin
				s_d.fifo_flush = 1'b1;
				s_d.fifo_wr = 1'b0;
				s_d.early_err = 1'b1;
			end
			if (ev.frame_end && !s_q.last_rx) begin
				s_d.in_frame = 1'b0;
				if (ev.partial && s_q.recv_ctrl[`RFC_RC_PARTIAL]) begin
					s_d.fifo_wr = 1'b1;
					s_d.fifo_data = ev.data;
				end
				if (s_q.recv_ctrl[`RFC_RC_DISTURB] && s_d.early_err) begin
					// FIFO already reset at the error; no done pulse
					s_d.fifo_wr = 1'b0;
				end else if (s_q.recv_ctrl[`RFC_RC_DISTURB]
					&& s_d.byte_cnt != `RFC_EARLY_BYTES) begin
					s_d.fifo_flush = 1'b1;
					s_d.fifo_wr = 1'b0;
				end else begin
					s_d.rx_done = 1'b1;
					if (s_q.recv_ctrl[`RFC_RC_MULTI]) begin
						s_d.fifo_wr = 1'b1;
						s_d.fifo_data = ev.err_reg;
					end
				end
				if (!s_q.recv_ctrl[`RFC_RC_MULTI]) begin
					s_d.active = 1'b0;
				end
			end
		end

		// Transmit waits for the guard interval
		if (tx_req) begin
			s_d.tx_pend = 1'b1;
		end
		if (s_q.tx_pend && guard_open && !guard_start) begin
			s_d.txgo = 1'b1;
			s_d.tx_pend = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_q <= '0;
			s_q.guard_ctrl <= `RFC_RST_GUARD_CTRL & 8'hf8;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops; waitrequest is the inverted ack flop
	assign avm_rsp.readdata = s_q.rdata;
	assign avm_rsp.waitrequest = !s_q.ack;
	assign tx_go_q = s_q.txgo;
	assign send_parity_append_q = s_q.frame_ctrl[`RFC_FC_TXPAR];
	assign frame_end_symbol_sel_q = s_q.frame_ctrl[3:2];
	assign frame_begin_symbol_sel_q = s_q.frame_ctrl[1:0];
	assign bitstream_frequency_q = s_q.recv_ctrl[2:0];
	assign rate_valid_q = s_q.rate_ok;
	assign receiver_active_q = s_q.active;
	assign fifo_wr_q.wr = s_q.fifo_wr;
	assign fifo_wr_q.data = s_q.fifo_data;
	assign fifo_wr_q.flush = s_q.fifo_flush;
	assign rx_done_irq_q = s_q.rx_done;
	assign frame_begin_irq_q = s_q.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_sof_sticky: assert property (@(posedge mclk) disable iff (srst)
		ev.sof |=> s_q.begin_det[`RFC_BD_SOF_SEEN])
		else $error("frame begin flag not set");
	chk_subc_sticky: assert property (@(posedge mclk) disable iff (srst)
		ev.subc |=> s_q.begin_det[`RFC_BD_SUBC_SEEN])
		else $error("subcarrier flag not set");
	chk_sof_irq: assert property (@(posedge mclk) disable iff (srst)
		ev.sof && s_q.begin_det[`RFC_BD_SOF_EN] |=> frame_begin_irq_q)
		else $error("frame begin interrupt missing");
	chk_subc_irq: assert property (@(posedge mclk) disable iff (srst)
		ev.subc && s_q.begin_det[`RFC_BD_SUBCARRIER_IRQ_ENABLE] |=> frame_begin_irq_q)
		else $error("subcarrier interrupt missing");
	chk_guard_word: assert property (@(posedge mclk) disable iff (srst)
		guard_time[10] == s_q.guard_ctrl[5] && guard_time[7:0] == s_q.guard_low)
		else $error("guard time assembled wrong");
	chk_tx_hold: assert property (@(posedge mclk) disable iff (srst)
		tx_go_q |-> $past(guard_open))
		else $error("transmit before guard elapsed");
	chk_no_done_short: assert property (@(posedge mclk) disable iff (srst)
		fifo_wr_q.flush |-> !rx_done_irq_q)
		else $error("receive done on disturbance");
	chk_stop_on_end: assert property (@(posedge mclk) disable iff (srst)
		rx_done_irq_q && !s_q.recv_ctrl[`RFC_RC_MULTI] |-> !receiver_active_q)
		else $error("receiver kept running");
	chk_rate_code: assert property (@(posedge mclk) disable iff (srst)
		rate_valid_q |-> bitstream_frequency_q inside {3'h2, 3'h3})
		else $error("rate valid on reserved code");
	chk_bus_answer: assert property (@(posedge mclk) disable iff (srst)
		(avm_req.read || avm_req.write) && avm_rsp.waitrequest |=> !avm_rsp.waitrequest)
		else $error("bus answer late");
	chk_live_bit: assert property (@(posedge mclk) disable iff (srst)
		avm_req.read && !s_q.ack && avm_req.address[7:2] == 6'(`RFC_IDX_BEGIN_DET)
		|=> avm_rsp.readdata[0] == $past(ev.subc))
		else $error("live bit not current");

	// Flag and interrupt checks
	chk_sof_hold: assert property (@(posedge mclk) disable iff (srst)
		s_q.begin_det[`RFC_BD_SOF_SEEN] && !(avm_req.write && s_q.ack)
		|=> s_q.begin_det[`RFC_BD_SOF_SEEN])
		else $error("frame begin flag lost");
	chk_subc_hold: assert property (@(posedge mclk) disable iff (srst)
		s_q.begin_det[`RFC_BD_SUBC_SEEN] && !(avm_req.write && s_q.ack)
		|=> s_q.begin_det[`RFC_BD_SUBC_SEEN])
		else $error("subcarrier flag lost");
	chk_irq_quiet: assert property (@(posedge mclk) disable iff (srst)
		!s_q.begin_det[`RFC_BD_SOF_EN] && !s_q.begin_det[`RFC_BD_SUBCARRIER_IRQ_ENABLE]
		&& !(avm_req.write && s_q.ack) |=> !frame_begin_irq_q)
		else $error("interrupt while disabled");

	// Receive path checks
	chk_early_flush: assert property (@(posedge mclk) disable iff (srst)
		s_q.in_frame && ev.err && s_q.recv_ctrl[`RFC_RC_DISTURB]
		&& s_q.byte_cnt != `RFC_EARLY_BYTES |=> fifo_wr_q.flush)
		else $error("early error kept");
	chk_coll_error: assert property (@(posedge mclk) disable iff (srst)
		s_q.in_frame && ev.coll && s_q.recv_ctrl[`RFC_RC_DISTURB]
		&& s_q.byte_cnt != `RFC_EARLY_BYTES |=> fifo_wr_q.flush)
		else $error("collision not an error");
	chk_partial_kept: assert property (@(posedge mclk) disable iff (srst)
		s_q.in_frame && ev.frame_end && !s_q.last_rx && ev.partial
		&& s_q.recv_ctrl[`RFC_RC_PARTIAL] && !s_q.recv_ctrl[`RFC_RC_DISTURB]
		&& !s_q.recv_ctrl[`RFC_RC_MULTI] |=> fifo_wr_q.wr && fifo_wr_q.data == $past(ev.data))
		else $error("partial byte dropped");
	chk_err_byte: assert property (@(posedge mclk) disable iff (srst)
		rx_done_irq_q && $past(s_q.recv_ctrl[`RFC_RC_MULTI])
		|-> fifo_wr_q.wr && fifo_wr_q.data == $past(ev.err_reg))
		else $error("error byte missing");

	cov_sof: cover property (@(posedge mclk) disable iff (srst) frame_begin_irq_q);
	cov_end_byte: cover property (@(posedge mclk) disable iff (srst) rx_done_irq_q && fifo_wr_q.wr);
	cov_flush: cover property (@(posedge mclk) disable iff (srst) fifo_wr_q.flush);
	cov_done: cover property (@(posedge mclk) disable iff (srst) rx_done_irq_q);
	cov_txgo: cover property (@(posedge mclk) disable iff (srst) tx_go_q);

endmodule : rfc_frame_cfg
`default_nettype wire

// ---- sim/rfc_tag_model.sv ----
// Behavioural model of the tag side feeding receiver events
`timescale 1ns/1ps
`default_nettype none
module rfc_tag_model (
	input wire logic mclk,          // System clock
	output rfc_pkg::rfc_rx_ev_t ev  // Receiver event word
);
	import rfc_pkg::*;
	// ----------------------------------------
	// Event driving
	// ----------------------------------------
	// Idle word at start, no subcarrier
	initial begin
		ev = '0;
	end
	// Hold one event word n cycles, then release with flipped data lines
	task automatic strobe(input rfc_rx_ev_t v, input int n);
		@(posedge mclk);
		v.subc = ev.subc;
		ev <= v;
		repeat (n) @(posedge mclk);
		ev <= '{subc: v.subc, data: ~v.data, par_bit: ~v.par_bit, err_reg: ~v.err_reg,
			default: 1'b0};
	endtask : strobe
	// Subcarrier is a plain level
	task automatic set_subc(input logic lvl);
		@(posedge mclk);
		ev.subc <= lvl;
	endtask : set_subc
endmodule : rfc_tag_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the frame and receive configuration block
`timescale 1ns/1ps
`default_nettype none
`include "rfc_consts.svh"
module testbench;
	import rfc_pkg::*;
	localparam int GC = `RFC_IDX_GUARD_CTRL;
	localparam int GL = `RFC_IDX_GUARD_LOW;
	localparam int FC = `RFC_IDX_FRAME_CTRL;
	localparam int BD = `RFC_IDX_BEGIN_DET;
	localparam int RC = `RFC_IDX_RECV_CTRL;
	localparam int UC = `RFC_UNIT_CARRIER;
	logic mclk, srst, tx_req, tx_go, par_app, rate_ok, rx_on, done_irq, sof_irq;
	logic [1:0] end_sym, beg_sym;
	logic [2:0] rate;
	logic [31:0] rd;
	logic [7:0] b;
	logic [7:0] m [0:63];
	logic [7:0] gotq [$];
	logic [7:0] expq [$];
	logic [7:0] sentq [$];
	rfc_avm_req_t req;
	rfc_avm_rsp_t rsp;
	rfc_rx_ev_t ev, v;
	rfc_fifo_wr_t fw;
	int error_cnt = 0, compares = 0, seed = 32'h3a93;
	int flushes = 0, dones = 0, gos = 0, cyc = 0;
	int idl [6] = '{GC, GL, FC, BD, RC, 8'h3f};
	rfc_frame_cfg dut (.mclk(mclk), .srst(srst), .avm_req(req), .avm_rsp(rsp),
		.rx_ev_in(ev), .tx_req(tx_req), .tx_go_q(tx_go), .send_parity_append_q(par_app),
		.frame_end_symbol_sel_q(end_sym), .frame_begin_symbol_sel_q(beg_sym),
		.bitstream_frequency_q(rate), .rate_valid_q(rate_ok), .receiver_active_q(rx_on),
		.fifo_wr_q(fw), .rx_done_irq_q(done_irq), .frame_begin_irq_q(sof_irq));
	rfc_tag_model tag (.mclk(mclk), .ev(ev));
	// ----------------------------------------
	// Clock, monitor, watchdog
	// ----------------------------------------
	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Collect FIFO writes and count pulses
	always @(posedge mclk) begin
		cyc++;
		if (fw.wr === 1'b1) gotq.push_back(fw.data);
		if (fw.flush === 1'b1) flushes++;
		if (done_irq === 1'b1) dones++;
		if (tx_go === 1'b1) gos++;
	end
	// Cut a hang short
	initial begin
		repeat (95000) @(posedge mclk);
		error_cnt++;
		$display("[ERR] run end expected done seen timeout");
		print_verdict();
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Writable bits of each register
	function automatic logic [7:0] wmask(input int idx);
		case (idx)
			GC: return 8'hf8;
			GL: return 8'hff;
			FC: return 8'hcf;
			BD: return 8'h24;
			RC: return 8'hcf;
			default: return 8'h00;
		endcase
	endfunction : wmask
	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input int idx, input logic [7:0] wd);
		int t;
		t = 0;
		@(posedge mclk);
		req <= '{address: 8'(idx * 4), read: !wr, write: wr, writedata: {24'h0, wd}};
		do begin
			@(posedge mclk);
			t++;
		end while (rsp.waitrequest !== 1'b0 && t < 50);
		rd = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		chk("wait states", t, 2);
	endtask : bus
	task automatic wreg(input int idx, input logic [7:0] wd);
		bus(1'b1, idx, wd);
		m[idx] = wd & wmask(idx);
	endtask : wreg
	task automatic rdchk(input int idx, input logic [7:0] extra);
		bus(1'b0, idx, 8'h00);
		chk("register", rd, {24'h0, m[idx] | extra});
	endtask : rdchk
	// Configuration outputs against the register model
	task automatic cfgchk();
		chk("parity append", par_app, m[FC][7]);
		chk("end symbol", end_sym, m[FC][3:2]);
		chk("begin symbol", beg_sym, m[FC][1:0]);
		chk("rate code", rate, m[RC][2:0]);
		chk("rate valid", rate_ok, m[RC][2:0] == 3'h2 || m[RC][2:0] == 3'h3);
	endtask : cfgchk
	task automatic pulse();
		@(posedge mclk);
		tx_req <= 1'b1;
		@(posedge mclk);
		tx_req <= 1'b0;
	endtask : pulse
	// One received frame; negative st, dn and act expectations are not checked
	task automatic rxrun(input logic [7:0] rc, input int nb, bad, kc, input logic [7:0] er,
		input int st, fl, dn, act);
		int f0, d0;
		wreg(RC, rc);
		gotq.delete();
		sentq.delete();
		f0 = flushes;
		d0 = dones;
		v = '0;
		v.sof = 1'b1;
		tag.strobe(v, 1);
		for (int i = 0; i < nb; i++) begin
			v = '0;
			v.byte_vld = 1'b1;
			v.data = 8'($random(seed));
			v.par_bit = ~^v.data;
			v.err = (i == bad) && kc == 0;
			v.coll = (i == bad) && kc == 1;
			sentq.push_back(v.data);
			tag.strobe(v, 1);
		end
		v = '0;
		v.frame_end = 1'b1;
		v.err_reg = er;
		v.partial = kc == 2;
		v.data = 8'($random(seed));
		if (kc == 2) sentq.push_back(v.data);
		tag.strobe(v, 2);
		repeat (10) @(posedge mclk); // FIFO looked at only after the frame
		expq = sentq;
		if (st > 1) expq.push_back(er);
		if (st > 0) begin
			chk("fifo count", gotq.size(), expq.size());
			foreach (expq[i]) chk("fifo byte", gotq[i], expq[i]);
		end
		chk("flush count", flushes - f0, fl);
		if (dn >= 0) chk("done count", dones - d0, dn);
		if (act >= 0) chk("receiver active", rx_on, act);
	endtask : rxrun
	// Guard interval from its origin event to the open state
	task automatic guard(input logic [7:0] gc, lo, input logic rx, input int exp);
		int t0, g0;
		wreg(GC, gc);
		wreg(GL, lo);
		v = '0;
		v.tx_end = !rx;
		v.frame_end = rx;
		tag.strobe(v, 2);
		t0 = cyc;
		g0 = gos;
		repeat (8) @(posedge mclk);
		pulse();
		bus(1'b0, `RFC_IDX_STATUS, 8'h00);
		chk("guard open", rd[1], 0);
		chk("early grant", gos - g0, 0);
		while (rd[1] !== 1'b1 && cyc - t0 < 50000) bus(1'b0, `RFC_IDX_STATUS, 8'h00);
		chk("guard span", cyc - t0 >= exp - 4 && cyc - t0 <= exp + 24, 1);
		pulse();
		repeat (4) @(posedge mclk);
		chk("grant", gos > g0, 1);
	endtask : guard
	task automatic print_verdict();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		tx_req = 1'b0;
		req = '0;
		foreach (m[i]) m[i] = 8'h00;
		m[GC] = `RFC_RST_GUARD_CTRL;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		// Reset values, then writes with all symbol and rate codes
		foreach (idl[k]) rdchk(idl[k], 8'h00);
		cfgchk();
		for (int c = 0; c < 8; c++) begin
			b = 8'($random(seed));
			wreg(FC, {b[7:4], 2'(c), 2'(c >> 1)});
			wreg(RC, {b[7:3], 3'(c)});
			wreg(GL, 8'($random(seed)));
			wreg(GC, 8'($random(seed)));
			wreg(8'h3f, b);
			foreach (idl[k]) rdchk(idl[k], 8'h00);
			cfgchk();
		end
		// Frame begin and subcarrier flags with the shared interrupt
		v = '0;
		v.sof = 1'b1;
		wreg(BD, 8'h24);
		tag.strobe(v, 2);
		repeat (8) @(posedge mclk);
		chk("begin irq", sof_irq, 1);
		rdchk(BD, 8'h10);
		wreg(BD, 8'h24);
		rdchk(BD, 8'h00);
		chk("begin irq", sof_irq, 0);
		tag.set_subc(1'b1);
		repeat (8) @(posedge mclk);
		rdchk(BD, 8'h03);
		chk("begin irq", sof_irq, 1);
		tag.set_subc(1'b0);
		repeat (8) @(posedge mclk);
		rdchk(BD, 8'h02);
		wreg(BD, 8'h00);
		v = '0;
		v.sof = 1'b1;
		tag.strobe(v, 2);
		repeat (8) @(posedge mclk);
		rdchk(BD, 8'h10);
		chk("begin irq", sof_irq, 0);
		// Receive: continuous, single, short, early error, collision, clean, partial
		wreg(FC, 8'h40);
		rxrun(8'h43, 4, -1, 0, 8'h5a, 2, 0, 1, 1);
		rxrun(8'h43, 1, -1, 0, 8'ha5, 2, 0, 1, 1);
		rxrun(8'h02, 3, -1, 0, 8'h11, 1, 0, 1, 0);
		rxrun(8'h0a, 2, -1, 0, 8'h22, -1, 1, 0, 0);
		rxrun(8'h0a, 5, 1, 0, 8'h44, -1, 1, 0, 0);
		rxrun(8'h0a, 5, 0, 1, 8'h55, -1, 1, 0, 0);
		rxrun(8'h0a, 3, -1, 0, 8'h33, 1, 0, 1, 0);
		rxrun(8'h82, 2, -1, 2, 8'h66, 1, 0, 1, 0);
		// Guard spans: upper bits, receive origin, half-bit unit at rate code 2
		guard(8'h08, 8'h02, 1'b0, 258 * UC);
		guard(8'h80, 8'h05, 1'b1, 5 * UC);
		guard(8'hc0, 8'h03, 1'b1, 3 * `RFC_HALF_26K);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
